// [position_unit_scaling.sv]
// Purpose: One axis of unit scaling between user units and encoder counts.
// Assumes: Driver link signals are synchronous to pclk.
// Notes:   Measured position is truncated toward zero in user units.
//
// The register offsets and register access over APB were chosen for this implementation.
`default_nettype none
module position_unit_scaling
   import scaling_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [31:0] pos_cmd,
   output logic             pos_cmd_valid,
   input  wire logic [31:0] fb_counts,
   input  wire logic        fb_valid,
   input  wire logic        link_up,
   input  wire logic [31:0] abs_position,
   output logic      [31:0] gear_ratio_numerator,
   output logic      [31:0] gear_ratio_denominator
);
   typedef enum logic [1:0] {st_idle, st_fb, st_abs} div_state_e;

   logic [31:0]      scale,     next_scale;
   logic [31:0]      num,       next_num;
   logic [31:0]      den,       next_den;
   logic [31:0]      target,    next_target;
   logic [31:0]      cmd,       next_cmd;
   logic             cmd_vld,   next_cmd_vld;
   logic [31:0]      measured,  next_measured;
   logic [31:0]      fb_hold,   next_fb_hold;
   logic [31:0]      abs_hold,  next_abs_hold;
   logic             pend_fb,   next_pend_fb;
   logic             pend_abs,  next_pend_abs;
   logic             abs_done,  next_abs_done;
   logic             link_q,    next_link_q;
   logic             neg,       next_neg;
   logic [31:0]      rdata,     next_rdata;
   div_state_e       state,     next_state;
   logic             div_start;
   logic [DVD_W-1:0] div_dvd;
   logic [DVS_W-1:0] div_dvs;
   logic             div_busy;
   logic             div_done;
   logic [DVD_W-1:0] div_quo;
   logic             wr_access;
   logic             mapped;
   logic             div_zero;
   logic             gear_ok;
   logic [63:0]      product;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] magnitude(input logic [31:0] v);
      magnitude = v[31] ? (~v + 32'h1) : v;
   endfunction : magnitude

   function automatic logic [31:0] apply_sign(input logic        s,
                                              input logic [31:0] v);
      apply_sign = s ? (~v + 32'h1) : v;
   endfunction : apply_sign

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_SCALE)    || (a == ADDR_GEAR_NUM) ||
                  (a == ADDR_GEAR_DEN) || (a == ADDR_TARGET)   ||
                  (a == ADDR_CMD)      || (a == ADDR_MEASURED) ||
                  (a == ADDR_STATUS)   || (a == ADDR_FEEDBACK);
   endfunction : is_mapped

   // ****************************************
   // Status terms
   // ****************************************
   assign mapped    = is_mapped(paddr);
   assign wr_access = psel && penable && pwrite && mapped;
   assign div_zero  = (scale == 32'h0) || (num == 32'h0);
   // Ratio is flagged good when num*100 >= den and num <= 100*den.
   assign gear_ok   = ({8'h0, num} * RATIO_LIMIT >= {8'h0, den}) &&
                      ({8'h0, num} <= {8'h0, den} * RATIO_LIMIT);
   // Signed user position times fixed-point scale.
   assign product   = $signed(target) * $signed({32'h0, scale});

   // ****************************************
   // Registers, link and divide sequencing
   // ****************************************
   always_comb begin
      next_scale    = scale;
      next_num      = num;
      next_den      = den;
      next_target   = target;
      next_cmd      = cmd;
      next_cmd_vld  = 1'b0;
      next_measured = measured;
      next_fb_hold  = fb_hold;
      next_abs_hold = abs_hold;
      next_pend_fb  = pend_fb;
      next_pend_abs = pend_abs;
      next_abs_done = abs_done;
      next_link_q   = link_up;
      next_neg      = neg;
      next_rdata    = rdata;
      next_state    = state;
      div_start     = 1'b0;
      div_dvd       = '0;
      div_dvs       = '0;
      if (wr_access) begin
         case (paddr)
            ADDR_SCALE:    next_scale = pwdata;
            ADDR_GEAR_NUM: next_num   = pwdata;
            ADDR_GEAR_DEN: next_den   = pwdata;
            ADDR_TARGET:   next_target = pwdata;
            default:       next_target = target;
         endcase
      end
      // A target write produces one rounded count command two cycles later.
      if (wr_access && (paddr == ADDR_TARGET)) begin
         next_cmd_vld = 1'b1;
      end
      if (cmd_vld) begin
         next_cmd = 32'((product + ROUND_HALF) >>> SCALE_FRAC);
      end
      // Divide start: clears come first so a new event in the same cycle wins.
      if ((state == st_idle) && !div_busy && !div_zero) begin
         if (pend_abs) begin
            next_pend_abs = 1'b0;
            next_neg      = abs_hold[31];
            // counts * den / (num * scale) in user units.
            div_dvd = {16'h0, 32'h0, magnitude(abs_hold)}
                      * {48'h0, den} << SCALE_FRAC;
            div_dvs = {32'h0, num} * {32'h0, scale};
            div_start  = 1'b1;
            next_state = st_abs;
         end else if (pend_fb) begin
            next_pend_fb = 1'b0;
            next_neg     = fb_hold[31];
            // Each conversion takes the whole count value of the latest held sample afresh.
            div_dvd = {48'h0, magnitude(fb_hold)} << SCALE_FRAC;
            div_dvs = {32'h0, scale};
            div_start  = 1'b1;
            next_state = st_fb;
         end
      end
      if (fb_valid) begin
         next_fb_hold = fb_counts;
         next_pend_fb = 1'b1;
      end
      if (link_up && !link_q) begin
         next_abs_hold = abs_position;
         next_pend_abs = 1'b1;
         next_abs_done = 1'b0;
      end
      if (!link_up) begin
         next_abs_done = 1'b0;
      end
      case (state)
         st_idle: next_state = next_state;
         st_fb: begin
            if (div_done) begin
               next_measured = apply_sign(neg, div_quo[31:0]);
               next_state    = st_idle;
            end
         end
         st_abs: begin
            if (div_done) begin
               next_measured = apply_sign(neg, div_quo[31:0]);
               next_abs_done = link_up;
               next_state    = st_idle;
            end
         end
         default: next_state = st_idle;
      endcase
      // Read data is captured in the setup phase.
      if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_SCALE:    next_rdata = scale;
            ADDR_GEAR_NUM: next_rdata = num;
            ADDR_GEAR_DEN: next_rdata = den;
            ADDR_TARGET:   next_rdata = target;
            ADDR_CMD:      next_rdata = cmd;
            ADDR_MEASURED: next_rdata = measured;
            ADDR_STATUS: begin
               next_rdata                = 32'h0;
               next_rdata[ST_BUSY]       = (state != st_idle);
               next_rdata[ST_GEAR_OK]    = gear_ok;
               next_rdata[ST_DIV_ZERO]   = div_zero;
               next_rdata[ST_LINK]       = link_up;
               next_rdata[ST_ABS_LOADED] = abs_done;
            end
            ADDR_FEEDBACK: next_rdata = fb_hold;
            default:       next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scale    <= RST_SCALE;
         num      <= RST_GEAR;
         den      <= RST_GEAR;
         target   <= 32'h0;
         cmd      <= 32'h0;
         cmd_vld  <= 1'b0;
         measured <= 32'h0;
         fb_hold  <= 32'h0;
         abs_hold <= 32'h0;
         pend_fb  <= 1'b0;
         pend_abs <= 1'b0;
         abs_done <= 1'b0;
         link_q   <= 1'b0;
         neg      <= 1'b0;
         rdata    <= 32'h0;
         state    <= st_idle;
      end else begin
         scale    <= next_scale;
         num      <= next_num;
         den      <= next_den;
         target   <= next_target;
         cmd      <= next_cmd;
         cmd_vld  <= next_cmd_vld;
         measured <= next_measured;
         fb_hold  <= next_fb_hold;
         abs_hold <= next_abs_hold;
         pend_fb  <= next_pend_fb;
         pend_abs <= next_pend_abs;
         abs_done <= next_abs_done;
         link_q   <= next_link_q;
         neg      <= next_neg;
         rdata    <= next_rdata;
         state    <= next_state;
      end
   end

   // ****************************************
   // Divider
   // ****************************************
   seq_divider u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (div_start),
      .dividend (div_dvd),
      .divisor  (div_dvs),
      .busy     (div_busy),
      .done     (div_done),
      .quotient (div_quo)
   );

   // ****************************************
   // Outputs
   // ****************************************
   // Command pulse follows the cycle in which the command register loads.
   logic cmd_pulse, next_cmd_pulse;
   always_comb begin
      next_cmd_pulse = cmd_vld;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_pulse <= 1'b0;
      end else begin
         cmd_pulse <= next_cmd_pulse;
      end
   end

   assign pos_cmd                = cmd;
   assign pos_cmd_valid          = cmd_pulse;
   assign gear_ratio_numerator   = num;
   assign gear_ratio_denominator = den;
   assign prdata                 = rdata;
   assign pready                 = 1'b1;
   assign pslverr                = psel && penable && !mapped;
endmodule : position_unit_scaling
`default_nettype wire

// [scaling_pkg.sv]
// Purpose: Constants shared by the position scaling block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Scale factor is unsigned fixed point with SCALE_FRAC bits.
//
// How it works
// - Commands to and feedback from the driver are always encoder counts.
// - A per-axis scale factor converts counts to user units.
// - Gear ratio times scale equals counts per user-unit distance for the absolute position only; commands and feedback use scale alone.
// - Scale factor has finitely many fractional digits: fixed point.
// - At link start, absolute position is converted into measured position.
`default_nettype none
package scaling_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  ADDR_SCALE     = 8'h00;
   localparam logic [7:0]  ADDR_GEAR_NUM  = 8'h04;
   localparam logic [7:0]  ADDR_GEAR_DEN  = 8'h08;
   localparam logic [7:0]  ADDR_TARGET    = 8'h0c;
   localparam logic [7:0]  ADDR_CMD       = 8'h10;
   localparam logic [7:0]  ADDR_MEASURED  = 8'h14;
   localparam logic [7:0]  ADDR_STATUS    = 8'h18;
   localparam logic [7:0]  ADDR_FEEDBACK  = 8'h1c;
   // ****************************************
   // Reset values and fields
   // ****************************************
   localparam int          SCALE_FRAC     = 16;
   localparam logic [31:0] RST_SCALE      = 32'h0001_0000;
   localparam logic [31:0] RST_GEAR       = 32'h0000_0001;
   localparam logic [63:0] ROUND_HALF     = 64'h0000_0000_0000_8000;
   localparam logic [39:0] RATIO_LIMIT    = 40'h00_0000_0064;
   localparam int          ST_BUSY        = 0;
   localparam int          ST_GEAR_OK     = 1;
   localparam int          ST_DIV_ZERO    = 2;
   localparam int          ST_LINK        = 3;
   localparam int          ST_ABS_LOADED  = 4;
   // ****************************************
   // Divider sizes
   // ****************************************
   localparam int          DVD_W          = 80;
   localparam int          DVS_W          = 64;
   localparam logic [6:0]  DIV_STEPS      = 7'h50;
endpackage : scaling_pkg
`default_nettype wire

// [seq_divider.sv]
// Purpose: Unsigned restoring divider, one quotient bit per clock.
// Assumes: Divisor is non-zero when start is raised.
// Notes:   Operands are captured at start; done is a one-cycle pulse.
`default_nettype none
module seq_divider
   import scaling_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic [DVD_W-1:0] dividend,
   input  wire logic [DVS_W-1:0] divisor,
   output logic                  busy,
   output logic                  done,
   output logic      [DVD_W-1:0] quotient
);
   logic [DVD_W-1:0] quo,  next_quo;
   logic [DVS_W:0]   rem,  next_rem;
   logic [DVS_W-1:0] dvs,  next_dvs;
   logic [6:0]       cnt,  next_cnt;
   logic             run,  next_run;
   logic             fin,  next_fin;
   logic [DVS_W:0]   trial;

   // ****************************************
   // Shift and subtract
   // ****************************************
   always_comb begin
      next_quo = quo;
      next_rem = rem;
      next_dvs = dvs;
      next_cnt = cnt;
      next_run = run;
      next_fin = 1'b0;
      trial    = {rem[DVS_W-1:0], quo[DVD_W-1]};
      if (start && !run) begin
         next_quo = dividend;
         next_rem = '0;
         next_dvs = divisor;
         next_cnt = DIV_STEPS;
         next_run = 1'b1;
      end else if (run) begin
         if (trial >= {1'b0, dvs}) begin
            next_rem = trial - {1'b0, dvs};
            next_quo = {quo[DVD_W-2:0], 1'b1};
         end else begin
            next_rem = trial;
            next_quo = {quo[DVD_W-2:0], 1'b0};
         end
         next_cnt = cnt - 7'h01;
         if (cnt == 7'h01) begin
            next_run = 1'b0;
            next_fin = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quo <= '0;
         rem <= '0;
         dvs <= '0;
         cnt <= '0;
         run <= 1'b0;
         fin <= 1'b0;
      end else begin
         quo <= next_quo;
         rem <= next_rem;
         dvs <= next_dvs;
         cnt <= next_cnt;
         run <= next_run;
         fin <= next_fin;
      end
   end

   assign busy     = run;
   assign done     = fin;
   assign quotient = quo;
endmodule : seq_divider
`default_nettype wire

// [position_unit_scaling_chk.sv]
// Purpose: Port assertions for the position scaling block.
// Assumes: Zero-wait APB and the command latency of the hand-over.
// Notes:   Bound to every instance of the block.
`default_nettype none
module position_unit_scaling_chk
   import scaling_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] pos_cmd,
   input wire logic        pos_cmd_valid,
   input wire logic [31:0] fb_counts,
   input wire logic        fb_valid,
   input wire logic        link_up,
   input wire logic [31:0] abs_position,
   input wire logic [31:0] gear_ratio_numerator,
   input wire logic [31:0] gear_ratio_denominator
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   logic wr;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_unmapped_err: assert property (acc && paddr >= 8'h20 |-> pslverr
      && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && paddr < 8'h20
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_cmd_latency: assert property (wr && paddr == ADDR_TARGET
      |-> ##2 pos_cmd_valid) else $error("command not issued");
   a_cmd_cause: assert property (pos_cmd_valid
      |-> $past(wr && paddr == ADDR_TARGET, 2)) else $error("stray command");
   a_cmd_hold: assert property (!pos_cmd_valid |-> $stable(pos_cmd))
      else $error("command changed without valid");
   a_gear_num: assert property (wr && paddr == ADDR_GEAR_NUM
      |-> ##2 gear_ratio_numerator == $past(pwdata, 2))
      else $error("numerator not passed on");
   a_gear_den: assert property (wr && paddr == ADDR_GEAR_DEN
      |-> ##2 gear_ratio_denominator == $past(pwdata, 2))
      else $error("denominator not passed on");
   a_gear_steady: assert property ($changed(gear_ratio_numerator)
      |-> $past(wr && paddr == ADDR_GEAR_NUM)
      || $past(wr && paddr == ADDR_GEAR_NUM, 2))
      else $error("numerator changed unasked");
endmodule : position_unit_scaling_chk
bind position_unit_scaling position_unit_scaling_chk u_chk (.*);
`default_nettype wire

// [servo_drive_model.sv]
// Purpose: Behavioural servo driver on the far side of the block.
// Assumes: Feedback returns the commanded counts after a fixed lag.
// Notes:   Feedback lines invert every cycle between samples.
`default_nettype none
module servo_drive_model #(
   parameter logic [31:0] TURN_LIMIT  = 32'h0000_0004,
   parameter logic [31:0] TURN_COUNTS = 32'h0000_2000,
   parameter logic [31:0] ABS_RAW     = 32'h0000_c3e8
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] pos_cmd,
   input  wire logic        pos_cmd_valid,
   input  wire logic [31:0] gear_ratio_numerator,
   input  wire logic [31:0] gear_ratio_denominator,
   output logic      [31:0] fb_counts,
   output logic             fb_valid,
   output logic      [31:0] abs_position
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] held;
   logic [2:0]  lag;
   logic [63:0] motor_pulses;
   assign abs_position =
      ABS_RAW % ((TURN_LIMIT + 32'h1) * TURN_COUNTS);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 32'h0;
         lag <= 3'h0;
         fb_valid <= 1'b0;
         fb_counts <= 32'h0;
         motor_pulses <= 64'h0;
      end else begin
         lag <= {lag[1:0], pos_cmd_valid};
         if (pos_cmd_valid) begin
            held <= pos_cmd;
            motor_pulses <= 64'($signed(pos_cmd) * gear_ratio_numerator
               / gear_ratio_denominator);
         end
         fb_valid <= lag[2];
         fb_counts <= lag[2] ? held : ~fb_counts;
      end
   end
endmodule : servo_drive_model
`default_nettype wire

// [test_position_unit_scaling.sv]
// Purpose: Self-checking bench for the position scaling block.
// Assumes: Zero-wait APB; driver model echoes commands as feedback.
// Notes:   Expected values are noted in queues and checked by monitors.
`default_nettype none
module test_position_unit_scaling
   import scaling_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SCALE_V = 32'h0001_8000;
   localparam logic [31:0] ABS_RAW = 32'h0000_c3e8;
   localparam logic [31:0] ABS_V   = ABS_RAW % (32'h5 * 32'h2000);
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, link_up = 1'b0, pready, pslverr, pos_cmd_valid;
   logic fb_valid;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, pos_cmd, fb_counts, abs_position;
   logic [31:0] num_o, den_o, last_cmd, t;
   logic [31:0] exp_rd[$], exp_cmd[$];
   int mismatches = 0, comparisons = 0, n;
   always #10 pclk = ~pclk;
   position_unit_scaling u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_cmd(pos_cmd),
      .pos_cmd_valid(pos_cmd_valid), .fb_counts(fb_counts),
      .fb_valid(fb_valid), .link_up(link_up), .abs_position(abs_position),
      .gear_ratio_numerator(num_o), .gear_ratio_denominator(den_o));
   servo_drive_model #(.ABS_RAW(ABS_RAW)) u_drive (.pclk(pclk),
      .presetn(presetn), .pos_cmd(pos_cmd), .pos_cmd_valid(pos_cmd_valid),
      .gear_ratio_numerator(num_o), .gear_ratio_denominator(den_o),
      .fb_counts(fb_counts), .fb_valid(fb_valid),
      .abs_position(abs_position));
   task automatic check(input string what, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         mismatches++;
         report_and_stop();
      end
      check("pslverr", 32'(a > ADDR_FEEDBACK), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   function automatic logic [31:0] to_counts(input logic [31:0] u);
      logic signed [63:0] p;
      p = $signed({{32{u[31]}}, u}) * $signed({32'h0, SCALE_V});
      return 32'((p + 64'sh8000) >>> 16);
   endfunction : to_counts
   function automatic logic [31:0] to_units(input logic [31:0] c,
                                            input logic [63:0] gn, gd);
      logic [63:0] q;
      q = ({32'h0, c[31] ? -c : c} * gd * 64'h1_0000) / (gn * SCALE_V);
      return c[31] ? -q[31:0] : q[31:0];
   endfunction : to_units
   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_rd.size() > 0)
         check("prdata", exp_rd.pop_front(), prdata);
      if (pos_cmd_valid === 1'b1 && exp_cmd.size() > 0)
         check("pos_cmd", exp_cmd.pop_front(), pos_cmd);
   end
   initial begin
      void'($urandom(46067));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_SCALE, 32'h0001_0000);
      rd(ADDR_GEAR_NUM, 32'h1);
      rd(ADDR_GEAR_DEN, 32'h1);
      apb(1'b1, 8'h20, 32'h5);
      rd(8'h20, 32'h0);
      check("num_o", 32'h1, num_o);
      $display("test 1 done");
      apb(1'b1, ADDR_SCALE, SCALE_V);
      apb(1'b1, ADDR_GEAR_NUM, 32'h3);
      apb(1'b1, ADDR_GEAR_DEN, 32'h2);
      rd(ADDR_SCALE, SCALE_V);
      rd(ADDR_GEAR_DEN, 32'h2);
      check("den_o", 32'h2, den_o);
      $display("test 2 done");
      for (int i = 0; i < 10; i++) begin
         t = (i < 4) ? (i == 3 ? 32'h3 : 32'h0 - i) : 32'($urandom());
         if (i >= 4) t = {{11{t[20]}}, t[20:0]};
         last_cmd = to_counts(t);
         exp_cmd.push_back(last_cmd);
         apb(1'b1, ADDR_TARGET, t);
      end
      n = 0;
      while (exp_cmd.size() > 0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      check("cmd drained", 32'h0, 32'(exp_cmd.size()));
      apb(1'b1, ADDR_CMD, 32'h55);
      rd(ADDR_CMD, last_cmd);
      repeat (200) @(posedge pclk);
      rd(ADDR_FEEDBACK, last_cmd);
      rd(ADDR_MEASURED, to_units(last_cmd, 64'h1, 64'h1));
      $display("test 3 done");
      link_up <= 1'b1;
      repeat (200) @(posedge pclk);
      rd(ADDR_MEASURED, to_units(ABS_V, 64'h3, 64'h2));
      rd(ADDR_STATUS, 32'h1a);
      $display("test 4 done");
      apb(1'b1, ADDR_GEAR_NUM, 32'h12d);
      apb(1'b1, ADDR_SCALE, 32'h0);
      rd(ADDR_STATUS, 32'h1c);
      link_up <= 1'b0;
      rd(ADDR_STATUS, 32'h04);
      $display("test 5 done");
      repeat (2) @(posedge pclk);
      report_and_stop();
   end
endmodule : test_position_unit_scaling
`default_nettype wire
